// File: include/srw_pkg.sv
package srw_pkg;

	// widths
	localparam int CNT_W = 15;

	// clock and internal time base
	localparam int CLK_HZ        = 200_000_000;
	localparam int TB_HZ         = 10_240;
	localparam int TB_DIV_CYCLES = CLK_HZ / TB_HZ;

	// internal timing, in milliseconds
	localparam int RESET_TIME_MS = 50;
	localparam int LONG_TIME_MS  = 1600;
	localparam int SHORT_TIME_MS = 100;

	// periods in time base ticks
	localparam logic [CNT_W-1:0] INT_RESET_TICKS =
		CNT_W'(RESET_TIME_MS * TB_HZ / 1000);
	localparam logic [CNT_W-1:0] INT_LONG_TICKS =
		CNT_W'(LONG_TIME_MS * TB_HZ / 1000);
	localparam logic [CNT_W-1:0] INT_SHORT_TICKS =
		CNT_W'(SHORT_TIME_MS * TB_HZ / 1000);
	localparam logic [CNT_W-1:0] EXT_RESET_TICKS = 15'h0200;
	localparam logic [CNT_W-1:0] EXT_LONG_TICKS  = 15'h1000;
	localparam logic [CNT_W-1:0] EXT_SHORT_TICKS = 15'h0400;

	// three-level kick input encoding
	localparam logic [1:0] KICK_LOW  = 2'h0;
	localparam logic [1:0] KICK_HIGH = 2'h1;
	localparam logic [1:0] KICK_MID  = 2'h2;

	// register map
	localparam logic [11:0] CTRL_ADDR   = 12'h000;
	localparam logic [11:0] STATUS_ADDR = 12'h004;

	// field positions
	localparam int CTRL_WD_EN_BIT    = 0;
	localparam int ST_RESET_N_BIT    = 0;
	localparam int ST_SUPPLY_N_BIT   = 1;
	localparam int ST_TIMEOUT_N_BIT  = 2;
	localparam int ST_FAIL_N_BIT     = 3;
	localparam int ST_BACKUP_BIT     = 4;
	localparam int ST_LONG_TO_BIT    = 5;
	localparam int ST_WD_ARMED_BIT   = 6;

	// reset values
	localparam logic CTRL_WD_EN_RST = 1'b1;

	typedef enum logic {
		RST_RUN,
		RST_HOLD
	} srw_rst_type;

	// synchronised pin group
	typedef struct packed {
		logic       supply_low;
		logic       vcc_below_batt;
		logic       fail_low;
		logic       ce_in_n;
		logic       tb_select;
		logic       tb_in;
		logic [1:0] kick;
	} srw_pins_type;

	localparam srw_pins_type PINS_RST = '{
		supply_low:     1'b1,
		vcc_below_batt: 1'b0,
		fail_low:       1'b1,
		ce_in_n:        1'b1,
		tb_select:      1'b1,
		tb_in:          1'b1,
		kick:           KICK_MID
	};

	typedef struct packed {
		srw_rst_type       rst_state;
		logic [CNT_W-1:0]  hold_cnt;
		logic [CNT_W-1:0]  wd_cnt;
		logic [CNT_W-1:0]  div_cnt;
		logic              tb_prev;
		logic              kick_last;
		logic              long_to;
		logic              wd_en;
		logic              reset_n;
		logic              reset_hi;
		logic              timeout_n;
		logic              fail_n;
		logic              backup;
		logic              supply_n;
		logic              ce_n;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} srw_state_type;

endpackage

// File: core/srw_sync.sv
module srw_sync #(
	parameter int                  W   = 8,
	parameter logic [W-1:0]        RST = '0
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [W-1:0]      d,
	output logic [W-1:0]           q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} srw_sync_state_type;

	srw_sync_state_type r_q;
	srw_sync_state_type r_d;

	// a bit moves only once the second and third stages agree
	always_comb begin
		r_d    = r_q;
		r_d.s1 = d;
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
		r_d.q  = (r_q.s2 & ~(r_q.s2 ^ r_q.s3)) | (r_q.q & (r_q.s2 ^ r_q.s3));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= '{s1: RST, s2: RST, s3: RST, q: RST};
		end else begin
			r_q <= r_d;
		end
	end

	assign q = r_q.q;
endmodule

// File: core/srw_supervisor.sv
// How it works
// - reset held low while supply sense is low or supply below battery
// - after supply sense recovers, reset stays low one more reset period
// - unserviced enabled watchdog fires a reset pulse of one reset period
// - each kick edge restarts the watchdog count; processor must kick in time
// - kick input at middle level disables the watchdog entirely
// - timeout flag goes low when kick input stays still past the timeout
// - timeout flag returns high on the next kick transition
// - timeout flag high while kick is mid or supply-low flag is low
// - fail warning goes low while fail sense input is below threshold
// - fail warning held low while main supply is below battery
// - gated chip enable follows input, forced high while supply sense low
// - backup flag high while the rail runs from the battery
// - supply-low flag follows supply sense with no hold delay
// - active-high reset is always the complement of active-low reset
// - select high uses internal time base, low uses external input
// - external clock edges drive both reset and watchdog counts
// - internal mode: time base input level picks short or long timeout
// - external mode: 1024 normal, 4096 after reset, 512 reset clocks
// - long timeout applies right after any reset ends
// - short timeout takes effect only after the first kick after reset
// - internal time base is a nominal 10.24 kHz tick
module srw_supervisor
	import srw_pkg::*;
#(
	parameter int TB_DIV = TB_DIV_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        supply_sense_in,
	input  wire logic        vcc_below_batt,
	input  wire logic        fail_sense_in,
	input  wire logic        ce_in_n,
	input  wire logic        timebase_select,
	input  wire logic        timebase_in,
	input  wire logic [1:0]  kick_input,
	output logic             reset_n,
	output logic             reset_hi,
	output logic             timeout_flag_n,
	output logic             fail_warn_n,
	output logic             backup_active,
	output logic             supply_low_n,
	output logic             ce_out_n
);
	import srw_pkg::*;

	srw_pins_type  pins_raw;
	srw_pins_type  pins;
	srw_state_type r_q;
	srw_state_type r_d;

	function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
		inc = v + CNT_W'(1);
	endfunction

	function automatic logic at_end(
		input logic [CNT_W-1:0] cnt,
		input logic [CNT_W-1:0] lim
	);
		at_end = (inc(cnt) == lim);
	endfunction

	// pins pass the three-stage synchroniser
	always_comb begin
		pins_raw.supply_low     = supply_sense_in;
		pins_raw.vcc_below_batt = vcc_below_batt;
		pins_raw.fail_low       = fail_sense_in;
		pins_raw.ce_in_n        = ce_in_n;
		pins_raw.tb_select      = timebase_select;
		pins_raw.tb_in          = timebase_in;
		pins_raw.kick           = kick_input;
	end

	srw_sync #(
		.W   ($bits(srw_pins_type)),
		.RST (PINS_RST)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pins_raw),
		.q       (pins)
	);

	logic             ext_mode;
	logic             tick;
	logic             cause;
	logic             kick_def;
	logic             kick_edge;
	logic             wd_armed;
	logic [CNT_W-1:0] reset_ticks;
	logic [CNT_W-1:0] wd_limit;
	logic             apb_access;
	logic             apb_done;

	always_comb begin
		ext_mode = !pins.tb_select;
		tick = ext_mode ? (pins.tb_in && !r_q.tb_prev)
			: (r_q.div_cnt == CNT_W'(TB_DIV - 1));
		cause = pins.supply_low || pins.vcc_below_batt;
		kick_def = (pins.kick == KICK_LOW) || (pins.kick == KICK_HIGH);
		kick_edge = kick_def && ((pins.kick == KICK_HIGH) != r_q.kick_last);
		wd_armed = r_q.wd_en && kick_def;
		reset_ticks = ext_mode ? EXT_RESET_TICKS : INT_RESET_TICKS;
		if (ext_mode) begin
			wd_limit = r_q.long_to ? EXT_LONG_TICKS : EXT_SHORT_TICKS;
		end else if (r_q.long_to || pins.tb_in) begin
			wd_limit = INT_LONG_TICKS;
		end else begin
			wd_limit = INT_SHORT_TICKS;
		end
		apb_access = psel && penable && !r_q.pready;
		apb_done = psel && penable && r_q.pready;
	end

	always_comb begin
		r_d = r_q;
		r_d.tb_prev = pins.tb_in;
		r_d.div_cnt = (ext_mode || tick) ? '0 : inc(r_q.div_cnt);
		if (kick_def) begin
			r_d.kick_last = (pins.kick == KICK_HIGH);
		end
		if (kick_edge) begin
			r_d.timeout_n = 1'b1;
		end
		unique case (r_q.rst_state)
			RST_RUN: begin
				if (cause) begin
					r_d.rst_state = RST_HOLD;
					r_d.hold_cnt  = '0;
					r_d.wd_cnt    = '0;
				end else if (kick_edge) begin
					r_d.wd_cnt  = '0;
					r_d.long_to = 1'b0;
				end else if (!wd_armed) begin
					r_d.wd_cnt = '0;
				end else if (tick) begin
					if (at_end(r_q.wd_cnt, wd_limit)) begin
						r_d.rst_state = RST_HOLD;
						r_d.hold_cnt  = '0;
						r_d.wd_cnt    = '0;
						r_d.timeout_n = 1'b0;
					end else begin
						r_d.wd_cnt = inc(r_q.wd_cnt);
					end
				end
			end
			RST_HOLD: begin
				r_d.wd_cnt = '0;
				if (cause) begin
					r_d.hold_cnt = '0;
				end else if (tick) begin
					if (at_end(r_q.hold_cnt, reset_ticks)) begin
						r_d.rst_state = RST_RUN;
						r_d.hold_cnt  = '0;
						r_d.long_to   = 1'b1;
					end else begin
						r_d.hold_cnt = inc(r_q.hold_cnt);
					end
				end
			end
		endcase
		if (!kick_def || pins.supply_low) begin
			r_d.timeout_n = 1'b1;
		end
		r_d.reset_n = (r_d.rst_state == RST_RUN);
		r_d.reset_hi = !r_d.reset_n;
		r_d.fail_n = !(pins.fail_low || pins.vcc_below_batt);
		r_d.backup = pins.vcc_below_batt;
		r_d.supply_n = !pins.supply_low;
		r_d.ce_n = pins.supply_low ? 1'b1 : pins.ce_in_n;

		// apb slave: one wait state, answer on the second access cycle
		r_d.pready  = apb_access;
		r_d.pslverr = 1'b0;
		r_d.prdata  = '0;
		if (apb_access) begin
			unique case (paddr)
				CTRL_ADDR: begin
					r_d.prdata[CTRL_WD_EN_BIT] = r_q.wd_en;
				end
				STATUS_ADDR: begin
					r_d.prdata[ST_RESET_N_BIT]   = r_q.reset_n;
					r_d.prdata[ST_SUPPLY_N_BIT]  = r_q.supply_n;
					r_d.prdata[ST_TIMEOUT_N_BIT] = r_q.timeout_n;
					r_d.prdata[ST_FAIL_N_BIT]    = r_q.fail_n;
					r_d.prdata[ST_BACKUP_BIT]    = r_q.backup;
					r_d.prdata[ST_LONG_TO_BIT]   = r_q.long_to;
					r_d.prdata[ST_WD_ARMED_BIT]  = wd_armed;
				end
				default: begin
					r_d.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_done && pwrite && paddr == CTRL_ADDR) begin
			r_d.wd_en = pwdata[CTRL_WD_EN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= '{
				rst_state: RST_HOLD,
				hold_cnt:  '0,
				wd_cnt:    '0,
				div_cnt:   '0,
				tb_prev:   1'b1,
				kick_last: 1'b0,
				long_to:   1'b1,
				wd_en:     CTRL_WD_EN_RST,
				reset_n:   1'b0,
				reset_hi:  1'b1,
				timeout_n: 1'b1,
				fail_n:    1'b0,
				backup:    1'b0,
				supply_n:  1'b0,
				ce_n:      1'b1,
				pready:    1'b0,
				pslverr:   1'b0,
				prdata:    '0
			};
		end else begin
			r_q <= r_d;
		end
	end

	assign reset_n        = r_q.reset_n;
	assign reset_hi       = r_q.reset_hi;
	assign timeout_flag_n = r_q.timeout_n;
	assign fail_warn_n    = r_q.fail_n;
	assign backup_active  = r_q.backup;
	assign supply_low_n   = r_q.supply_n;
	assign ce_out_n       = r_q.ce_n;
	assign prdata         = r_q.prdata;
	assign pready         = r_q.pready;
	assign pslverr        = r_q.pslverr;
endmodule

// File: verification/srw_monitor.sv
module srw_monitor (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       supply_sense_in,
	input wire logic       vcc_below_batt,
	input wire logic       fail_sense_in,
	input wire logic       ce_in_n,
	input wire logic [1:0] kick_input,
	input wire logic       reset_n,
	input wire logic       reset_hi,
	input wire logic       timeout_flag_n,
	input wire logic       fail_warn_n,
	input wire logic       backup_active,
	input wire logic       supply_low_n,
	input wire logic       ce_out_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_cmpl;
		reset_hi == !reset_n;
	endproperty
	a_cmpl: assert property (p_cmpl) else $error("reset pair split");
	property p_sup;
		$changed(supply_sense_in) ##1 $stable(supply_sense_in) [*6]
			|-> supply_low_n == !supply_sense_in;
	endproperty
	a_sup: assert property (p_sup) else $error("supply flag wrong");
	property p_fail;
		$changed({fail_sense_in, vcc_below_batt}) ##1
			$stable({fail_sense_in, vcc_below_batt}) [*6]
			|-> fail_warn_n == !(fail_sense_in | vcc_below_batt);
	endproperty
	a_fail: assert property (p_fail) else $error("fail warn wrong");
	property p_ce;
		$changed({ce_in_n, supply_sense_in}) ##1
			$stable({ce_in_n, supply_sense_in}) [*6]
			|-> ce_out_n == (ce_in_n | supply_sense_in);
	endproperty
	a_ce: assert property (p_ce) else $error("gated enable wrong");
	property p_hold;
		!supply_low_n || backup_active |-> !reset_n;
	endproperty
	a_hold: assert property (p_hold) else $error("reset not held");
	property p_rise;
		$rose(supply_low_n) |-> (!reset_n) [*8];
	endproperty
	a_rise: assert property (p_rise) else $error("reset released early");
	property p_wmid;
		kick_input[1] [*7] |-> timeout_flag_n;
	endproperty
	a_wmid: assert property (p_wmid) else $error("flag low at mid");
	property p_wlow;
		!supply_low_n |-> timeout_flag_n;
	endproperty
	a_wlow: assert property (p_wlow) else $error("flag low in low supply");
	property p_wfire;
		$fell(timeout_flag_n) |-> !reset_n;
	endproperty
	a_wfire: assert property (p_wfire) else $error("timeout no reset");
endmodule

bind srw_supervisor srw_monitor u_mon (.pclk, .presetn, .supply_sense_in,
	.vcc_below_batt, .fail_sense_in, .ce_in_n, .kick_input, .reset_n,
	.reset_hi, .timeout_flag_n, .fail_warn_n, .backup_active,
	.supply_low_n, .ce_out_n);

// File: verification/srw_cpu_model.sv
module srw_cpu_model
	import srw_pkg::*;
(
	input  wire logic [1:0] mode,
	input  wire logic       pclk,
	output logic [1:0]      kick_input = KICK_MID
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] n   = 6'h00;
	logic       lvl = 1'b0;
	// mode 0 kicks, 1 holds the last level, 2 floats mid
	always @(posedge pclk) begin
		n <= n + 6'h01;
		if (mode == 2'h0 && n == 6'h00) lvl <= !lvl;
		kick_input <= mode == 2'h2 ? KICK_MID : lvl ? KICK_HIGH : KICK_LOW;
	end
endmodule

// File: verification/srw_supervisor_bench.sv
module srw_supervisor_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import srw_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready, pslverr, e, sup = 0, vbb = 0, fsi = 0, cei = 1;
	logic        tsel = 0, tbi = 0, reset_n, reset_hi, timeout_flag_n;
	logic        tb_low = 0;
	logic        fail_warn_n, backup_active, supply_low_n, ce_out_n;
	logic [1:0]  kick, mode = 2'h2;
	int          failures = 0, checks = 0, tk = 0, drops = 0, dv = 0;
	srw_supervisor #(.TB_DIV(4)) u_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.supply_sense_in(sup), .vcc_below_batt(vbb), .fail_sense_in(fsi),
		.ce_in_n(cei), .timebase_select(tsel), .timebase_in(tbi),
		.kick_input(kick), .reset_n, .reset_hi, .timeout_flag_n,
		.fail_warn_n, .backup_active, .supply_low_n, .ce_out_n);
	srw_cpu_model u_cpu (.mode, .pclk, .kick_input(kick));
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		dv <= dv == 5 ? 0 : dv + 1;
		tbi <= !tb_low && dv < 3;
	end
	always @(posedge tbi) tk++;
	always @(negedge reset_n) drops++;
	task automatic chk(input logic [31:0] g, w);
		checks++;
		if (g !== w) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, g, w);
		end
	endtask
	task automatic near(input int g, w);
		chk(g > w - 4 && g < w + 4 ? w : g, w);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic wsig(input logic s, v);
		int n;
		n = 0;
		while ((s ? timeout_flag_n : reset_n) !== v && n < 40000) begin
			@(posedge pclk);
			n++;
		end
		chk(s ? timeout_flag_n : reset_n, v);
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic t_sup;
		int t;
		t = tk;
		wsig(0, 1);
		near(tk - t, 512);
		cei <= 0;
		sup <= 1;
		wt(8);
		chk(reset_n, 0);
		chk(ce_out_n, 1);
		sup <= 0;
		wt(1500);
		chk(supply_low_n, 1);
		chk(reset_n, 0);
		vbb <= 1;
		wt(8);
		chk(backup_active, 1);
		chk(fail_warn_n, 0);
		wt(300);
		vbb <= 0;
		t = tk;
		wsig(0, 1);
		near(tk - t, 512);
		chk(ce_out_n, 0);
		fsi <= 1;
		wt(8);
		chk(fail_warn_n, 0);
		fsi <= 0;
		wt(8);
		chk({fail_warn_n, backup_active}, 2'h2);
	endtask
	task automatic t_wd;
		int t, d;
		d = drops;
		mode <= 0;
		wt(9000);
		chk(drops - d, 0);
		@(kick);
		mode <= 1;
		t = tk;
		wsig(1, 0);
		near(tk - t, 1024);
		chk(reset_n, 0);
		t = tk;
		wsig(0, 1);
		near(tk - t, 512);
		mode <= 0;
		@(kick);
		mode <= 1;
		wt(8);
		chk(timeout_flag_n, 1);
		wsig(1, 0);
		wsig(0, 1);
		t = tk;
		wsig(0, 0);
		near(tk - t, 4096);
		mode <= 2;
		wt(10);
		chk(timeout_flag_n, 1);
		wsig(0, 1);
		mode <= 0;
		repeat (2) @(kick);
		wt(8);
		mode <= 2;
		d = drops;
		wt(8000);
		chk(drops - d, 0);
	endtask
	task automatic t_reg;
		int d;
		apb(0, CTRL_ADDR, 32'h0);
		chk(r, 32'h1);
		mode <= 0;
		@(kick);
		mode <= 1;
		apb(1, CTRL_ADDR, 32'h0);
		apb(0, CTRL_ADDR, 32'h0);
		chk(r, 32'h0);
		d = drops;
		wt(6800);
		chk(drops - d, 0);
		chk(timeout_flag_n, 1);
		apb(0, STATUS_ADDR, 32'h0);
		chk(r, 32'h0000000F);
		apb(0, 12'h008, 32'h0);
		chk(r, 32'h0);
		chk(e, 1);
	endtask
	task automatic t_int;
		time t0;
		tsel <= 1;
		wt(10);
		sup <= 1;
		wt(20);
		sup <= 0;
		t0 = $time;
		wsig(0, 1);
		near(int'(($time - t0) / 20), 512);
		tb_low <= 1;
		apb(1, CTRL_ADDR, 32'h1);
		mode <= 0;
		@(kick);
		mode <= 1;
		t0 = $time;
		wsig(1, 0);
		near(int'(($time - t0) / 20), 1024);
	endtask
	initial begin
		wt(16);
		presetn <= 1;
		t_sup();
		t_wd();
		t_reg();
		t_int();
		report_and_stop();
	end
	initial begin
		#480000;
		failures++;
		report_and_stop();
	end
endmodule
